// [src/loop_cfg_pkg.sv]
package loop_cfg_pkg;

  // Byte offsets of the bank, as seen through the serial register pointer.
  localparam logic [7:0] OFF_DENOMINATOR_HIGH_BYTE = 8'h1E;
  localparam logic [7:0] OFF_DENOMINATOR_MID_BYTE = 8'h1F;
  localparam logic [7:0] OFF_DENOMINATOR_LOW_BYTE = 8'h20;
  localparam logic [7:0] OFF_MODULATOR_CONTROL = 8'h21;
  localparam logic [7:0] OFF_LOOP_CONTROL_PRIMARY = 8'h22;
  localparam logic [7:0] OFF_LOOP_CONTROL_SECONDARY = 8'h23;
  localparam logic [7:0] OFF_FILTER_RESISTOR_TWO_SELECT = 8'h24;
  localparam logic [7:0] OFF_FILTER_CAPACITOR_ONE_SELECT = 8'h25;

  // The bank is a contiguous run of entries starting at the lowest offset.
  localparam int NUM_REGS = 8;
  localparam logic [7:0] BANK_BASE = OFF_DENOMINATOR_HIGH_BYTE;
  localparam logic [7:0] BANK_LAST = OFF_FILTER_CAPACITOR_ONE_SELECT;

  // Entry indices, derived from the offsets.
  localparam logic [2:0] IDX_DEN_HIGH = 3'(OFF_DENOMINATOR_HIGH_BYTE - BANK_BASE);
  localparam logic [2:0] IDX_DEN_MID = 3'(OFF_DENOMINATOR_MID_BYTE - BANK_BASE);
  localparam logic [2:0] IDX_DEN_LOW = 3'(OFF_DENOMINATOR_LOW_BYTE - BANK_BASE);
  localparam logic [2:0] IDX_MOD_CTRL = 3'(OFF_MODULATOR_CONTROL - BANK_BASE);
  localparam logic [2:0] IDX_LOOP_PRI = 3'(OFF_LOOP_CONTROL_PRIMARY - BANK_BASE);
  localparam logic [2:0] IDX_LOOP_SEC = 3'(OFF_LOOP_CONTROL_SECONDARY - BANK_BASE);
  localparam logic [2:0] IDX_R2_SEL = 3'(OFF_FILTER_RESISTOR_TWO_SELECT - BANK_BASE);
  localparam logic [2:0] IDX_C1_SEL = 3'(OFF_FILTER_CAPACITOR_ONE_SELECT - BANK_BASE);

  // Per-entry tables, entry 7 first: writable bits, reset value, constant read bits.
  localparam logic [NUM_REGS-1:0][7:0] WR_MASK = {
    8'h07, 8'hFF, 8'h74, 8'hEF, 8'h0F, 8'hFF, 8'hFF, 8'h3F
  };
  localparam logic [NUM_REGS-1:0][7:0] RST_VAL = {
    8'h00, 8'h08, 8'h00, 8'h28, 8'h0C, 8'h00, 8'h00, 8'h00
  };
  localparam logic [NUM_REGS-1:0][7:0] RD_CONST = {
    8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // Field positions.
  localparam int DEN_HIGH_W = 6;
  localparam int DITHER_LSB = 2;
  localparam int ORDER_LSB = 0;
  localparam int DOUBLER_BIT = 5;
  localparam int PUMP_CUR_LSB = 0;
  localparam int PHASE_LSB = 4;
  localparam int C3_BIT = 2;
  localparam int C1_LSB = 0;

  // Serial framing constants.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Configuration delivered to the analog loop.
  typedef struct packed {
    logic [21:0] fractional_denominator;
    logic [1:0] modulator_dither_select;
    logic [1:0] modulator_order;
    logic doubler_enable;
    logic [3:0] pump_current_code;
    logic [2:0] pump_phase_offset_code;
    logic third_pole_capacitor_enable;
    logic [7:0] filter_resistor_two_code;
    logic [2:0] filter_capacitor_one_code;
  } loop_cfg_s;

  // Serial target states.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } target_state_e;

endpackage : loop_cfg_pkg

// [src/pin_sync.sv]
`timescale 1ns/1ps

// Two-stage synchroniser, one pair of flops per bit.
module pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_LEVEL = '1
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Asynchronous input and its synchronised copy.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // Each bit is captured independently; the first stage feeds only the second.
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    logic meta_q;
    logic stable_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_q <= RST_LEVEL[g];
        stable_q <= RST_LEVEL[g];
      end else begin
        meta_q <= async_i[g];
        stable_q <= meta_q;
      end
    end
    assign sync_o[g] = stable_q;
  end

endmodule : pin_sync

// [src/pll_fractional_loop_config_bank.sv]
`timescale 1ns/1ps

// Summary of operation
// - Denominator low byte is read-write, all eight bits, reset to zero.
// - Denominator is 22 bits: high six, middle eight, then the low byte.
// - Dither field bits 3:2, reset 3; 0 weak, 3 off, 1-2 reserved.
// - Modulator order bits 1:0, reset 0; 0 integer, 3 third order.
// - Bit 5 set enables the reference doubler; resets to one.
// - Pump current code bits 3:0, reset 8; host uses codes 4 or 8.
// - Pump phase shift code bits 6:4, reset 0 meaning no delay.
// - Bit 2 zero gives second-order filter; one enables the third capacitor.
// - Resistor takes a full eight-bit code, reset to 8.
// - Capacitor C1 code bits 2:0, reset 0; five plus fifty pF per step.
module pll_fractional_loop_config_bank #(
  // Seven-bit target address; the default value is arbitrary.
  parameter logic [6:0] TARGET_ADDR = 7'h58
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Serial control bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Loop configuration.
  output loop_cfg_pkg::loop_cfg_s loop_cfg_o
);

  // Synchronised pins and their previous samples.
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;

  // Target state.
  loop_cfg_pkg::target_state_e state_q;
  loop_cfg_pkg::target_state_e state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic oe_n_q;
  logic oe_n_d;
  logic wr_en;

  // Register storage.
  logic [loop_cfg_pkg::NUM_REGS-1:0][7:0] bank_q;
  logic [loop_cfg_pkg::NUM_REGS-1:0][7:0] bank_view;

  // Both pins idle high, so the synchroniser resets to one.
  pin_sync #(
    .WIDTH(2),
    .RST_LEVEL(2'h3)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({scl_i, sda_i}),
    .sync_o({scl_s, sda_s})
  );

  // Previous samples for edge and condition detection.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Bus events. Start and stop are only recognised while the clock is high.
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire byte_done = (bit_cnt_q == loop_cfg_pkg::BYTE_BITS);
  wire addr_match = (shift_q[7:1] == TARGET_ADDR);

  // Pointer decode. Outside the bank, reads give a fixed value and writes are dropped.
  wire ptr_in_bank = (ptr_q >= loop_cfg_pkg::BANK_BASE) && (ptr_q <= loop_cfg_pkg::BANK_LAST);
  wire [7:0] ptr_offset = ptr_q - loop_cfg_pkg::BANK_BASE;
  wire [2:0] ptr_index = ptr_offset[2:0];
  wire [7:0] rd_data = ptr_in_bank ? bank_view[ptr_index] : loop_cfg_pkg::UNMAPPED_READ;

  // Protocol sequencing. Data changes on falling clock edges and is sampled on rising ones.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    tx_d = tx_q;
    bit_cnt_d = bit_cnt_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_n_d = oe_n_q;
    wr_en = 1'b0;
    if (stop_seen) begin
      state_d = loop_cfg_pkg::ST_IDLE;
      oe_n_d = 1'b1;
    end else if (start_seen) begin
      // A repeated start keeps the pointer, so a write of the pointer can precede a read.
      state_d = loop_cfg_pkg::ST_ADDR;
      bit_cnt_d = '0;
      oe_n_d = 1'b1;
    end else begin
      case (state_q)
        loop_cfg_pkg::ST_ADDR,
        loop_cfg_pkg::ST_PTR,
        loop_cfg_pkg::ST_WR: begin
          if (scl_rise && !byte_done) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_d = '0;
            oe_n_d = 1'b0;
            if (state_q == loop_cfg_pkg::ST_ADDR) begin
              if (addr_match) begin
                rw_d = shift_q[0];
                state_d = loop_cfg_pkg::ST_ADDR_ACK;
              end else begin
                oe_n_d = 1'b1;
                state_d = loop_cfg_pkg::ST_IDLE;
              end
            end else if (state_q == loop_cfg_pkg::ST_PTR) begin
              ptr_d = shift_q;
              state_d = loop_cfg_pkg::ST_PTR_ACK;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
              state_d = loop_cfg_pkg::ST_WR_ACK;
            end
          end
        end
        loop_cfg_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_d = {rd_data[6:0], 1'b0};
              oe_n_d = rd_data[7];
              bit_cnt_d = 4'h1;
              state_d = loop_cfg_pkg::ST_RD;
            end else begin
              oe_n_d = 1'b1;
              state_d = loop_cfg_pkg::ST_PTR;
            end
          end
        end
        loop_cfg_pkg::ST_PTR_ACK,
        loop_cfg_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            oe_n_d = 1'b1;
            state_d = loop_cfg_pkg::ST_WR;
          end
        end
        loop_cfg_pkg::ST_RD: begin
          if (scl_fall) begin
            if (byte_done) begin
              oe_n_d = 1'b1;
              bit_cnt_d = '0;
              ptr_d = ptr_q + 8'h01;
              state_d = loop_cfg_pkg::ST_RD_ACK;
            end else begin
              oe_n_d = tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        loop_cfg_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_d = loop_cfg_pkg::ST_IDLE;
            end else begin
              tx_d = {rd_data[6:0], 1'b0};
              oe_n_d = rd_data[7];
              bit_cnt_d = 4'h1;
              state_d = loop_cfg_pkg::ST_RD;
            end
          end
        end
        default: begin
          state_d = loop_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Target state flops.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= loop_cfg_pkg::ST_IDLE;
      shift_q <= '0;
      tx_q <= '0;
      bit_cnt_q <= '0;
      ptr_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      bit_cnt_q <= bit_cnt_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_n_q <= oe_n_d;
    end
  end

  // The pin is open drain: only a low level is ever driven.
  assign sda_o = 1'b0;
  assign sda_oe_n_o = oe_n_q;

  // Storage entries. Only writable bits keep state; the rest read back fixed values,
  // which keeps a stray write from ever reaching the analog side.
  for (genvar g = 0; g < loop_cfg_pkg::NUM_REGS; g++) begin : g_entry
    wire entry_wr = wr_en && ptr_in_bank && (ptr_index == 3'(g));
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        bank_q[g] <= loop_cfg_pkg::RST_VAL[g] & loop_cfg_pkg::WR_MASK[g];
      end else if (entry_wr) begin
        bank_q[g] <= shift_q & loop_cfg_pkg::WR_MASK[g];
      end
    end
    assign bank_view[g] = bank_q[g] | loop_cfg_pkg::RD_CONST[g];
  end

  // Denominator assembled from its three bytes, most significant first.
  assign loop_cfg_o.fractional_denominator = {
    bank_q[loop_cfg_pkg::IDX_DEN_HIGH][loop_cfg_pkg::DEN_HIGH_W-1:0],
    bank_q[loop_cfg_pkg::IDX_DEN_MID],
    bank_q[loop_cfg_pkg::IDX_DEN_LOW]
  };

  // Modulator fields. Reserved codes pass through unchanged.
  assign loop_cfg_o.modulator_dither_select =
    bank_q[loop_cfg_pkg::IDX_MOD_CTRL][loop_cfg_pkg::DITHER_LSB +: 2];
  assign loop_cfg_o.modulator_order =
    bank_q[loop_cfg_pkg::IDX_MOD_CTRL][loop_cfg_pkg::ORDER_LSB +: 2];

  // Charge pump, doubler and third-pole capacitor controls.
  assign loop_cfg_o.doubler_enable =
    bank_q[loop_cfg_pkg::IDX_LOOP_PRI][loop_cfg_pkg::DOUBLER_BIT];
  assign loop_cfg_o.pump_current_code =
    bank_q[loop_cfg_pkg::IDX_LOOP_PRI][loop_cfg_pkg::PUMP_CUR_LSB +: 4];
  assign loop_cfg_o.pump_phase_offset_code =
    bank_q[loop_cfg_pkg::IDX_LOOP_SEC][loop_cfg_pkg::PHASE_LSB +: 3];
  assign loop_cfg_o.third_pole_capacitor_enable =
    bank_q[loop_cfg_pkg::IDX_LOOP_SEC][loop_cfg_pkg::C3_BIT];

  // Loop filter component codes.
  assign loop_cfg_o.filter_resistor_two_code = bank_q[loop_cfg_pkg::IDX_R2_SEL];
  assign loop_cfg_o.filter_capacitor_one_code =
    bank_q[loop_cfg_pkg::IDX_C1_SEL][loop_cfg_pkg::C1_LSB +: 3];

endmodule : pll_fractional_loop_config_bank

// [sim/loop_cfg_props.sv]
`timescale 1ns/1ps

// Port-level checks on the configuration bank.
module loop_cfg_props (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Serial pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // Loop configuration.
  input wire loop_cfg_pkg::loop_cfg_s loop_cfg_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // Reset values must already stand when the host may first speak.
  rst_den_a: assert property ($rose(rst_b_i) |-> loop_cfg_o.fractional_denominator == 22'h000000)
    else $error("denominator not cleared by reset");
  rst_mod_a: assert property ($rose(rst_b_i) |-> loop_cfg_o.modulator_dither_select == 2'h3
    && loop_cfg_o.modulator_order == 2'h0) else $error("modulator reset value wrong");
  rst_pump_a: assert property ($rose(rst_b_i) |-> loop_cfg_o.doubler_enable &&
    loop_cfg_o.pump_current_code == 4'h8) else $error("doubler or pump reset value wrong");
  rst_phase_a: assert property ($rose(rst_b_i) |-> loop_cfg_o.pump_phase_offset_code == 3'h0
    && !loop_cfg_o.third_pole_capacitor_enable) else $error("phase or third pole reset value wrong");
  rst_filter_a: assert property ($rose(rst_b_i) |-> loop_cfg_o.filter_resistor_two_code == 8'h08
    && loop_cfg_o.filter_capacitor_one_code == 3'h0) else $error("filter reset value wrong");

  // A stored byte lands while the clock pin is low and the byte is being acknowledged.
  cfg_low_a: assert property ($changed(loop_cfg_o) |-> !scl_i && !$past(scl_i))
    else $error("configuration changed while clock high");
  cfg_ack_a: assert property ($changed(loop_cfg_o) |-> ##[0:1] !sda_oe_n_o)
    else $error("configuration changed without acknowledge");
  cfg_gap_a: assert property ($changed(loop_cfg_o) |=> $stable(loop_cfg_o)[*8])
    else $error("configuration changed twice within one byte");
  den_part_a: assert property ($changed(loop_cfg_o.fractional_denominator[7:0]) |->
    $stable(loop_cfg_o.fractional_denominator[21:8])) else $error("low byte write disturbed upper denominator");
endmodule : loop_cfg_props

// [sim/i2c_host_model.sv]
`timescale 1ns/1ps

// Behavioural bus host; open drain, so a one on sda_o releases the wire.
module i2c_host_model (
  // Clock.
  input wire logic clk_sys_i,
  // Bus pins.
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Both lines idle high until the first start.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Pins move on falling edges, so the target never samples a moving level.
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : hold

  // Serves as first or repeated start; every clock phase exceeds eight cycles.
  task automatic start_cond();
    sda_o = 1'b1;
    hold(5);
    scl_o = 1'b1;
    hold(10);
    sda_o = 1'b0;
    hold(10);
    scl_o = 1'b0;
    hold(4);
  endtask : start_cond

  task automatic stop_cond();
    sda_o = 1'b0;
    hold(5);
    scl_o = 1'b1;
    hold(10);
    sda_o = 1'b1;
    hold(10);
  endtask : stop_cond

  // Nine bit slots; data changes only while the clock is low.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_o = tx[i];
      hold(6);
      scl_o = 1'b1;
      hold(5);
      rx[i] = sda_i;
      hold(5);
      scl_o = 1'b0;
      hold(4);
    end
  endtask : xfer
endmodule : i2c_host_model

// [sim/pll_fractional_loop_config_bank_tb.sv]
`timescale 1ns/1ps

module pll_fractional_loop_config_bank_tb;
  localparam logic [6:0] ADDR = 7'h2D; // Arbitrary target address.
  logic clk_sys_i;
  logic rst_b_i;
  logic scl_w;
  logic host_sda;
  logic sda_o;
  logic sda_oe_n_o;
  loop_cfg_pkg::loop_cfg_s loop_cfg_o;
  logic [7:0] img [8];
  logic [7:0] wd [8];
  logic [15:0] seed;
  logic [8:0] r;
  int err_count;
  int num_checks;

  // Pulled-up wire: either party may pull it low.
  wire sda_w = host_sda & (sda_oe_n_o | sda_o);

  pll_fractional_loop_config_bank #(.TARGET_ADDR(ADDR)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .loop_cfg_o(loop_cfg_o));
  i2c_host_model host (.clk_sys_i(clk_sys_i), .scl_o(scl_w), .sda_o(host_sda), .sda_i(sda_w));

  // Free-running 50 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Read view of one entry: writable bits only, plus the constant reserved pair.
  function automatic logic [7:0] rd_exp(input logic [2:0] i);
    logic [7:0] m [8] = '{8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'hEF, 8'h74, 8'hFF, 8'h07};
    return (img[i] & m[i]) | (i == 3'd5 ? 8'h03 : 8'h00);
  endfunction : rd_exp

  function automatic loop_cfg_pkg::loop_cfg_s cfg_exp();
    loop_cfg_pkg::loop_cfg_s c;
    c.fractional_denominator = {img[0][5:0], img[1], img[2]};
    c.modulator_dither_select = img[3][3:2];
    c.modulator_order = img[3][1:0];
    c.doubler_enable = img[4][5];
    c.pump_current_code = img[4][3:0];
    c.pump_phase_offset_code = img[5][6:4];
    c.third_pole_capacitor_enable = img[5][2];
    c.filter_resistor_two_code = img[6];
    c.filter_capacitor_one_code = img[7][2:0];
    return c;
  endfunction : cfg_exp

  task automatic cmp_b(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : cmp_b

  task automatic cmp_cfg(input loop_cfg_pkg::loop_cfg_s e);
    num_checks++;
    if (loop_cfg_o !== e) begin
      err_count++;
      $display("unexpected loop_cfg_o: expected %h, seen %h", e, loop_cfg_o);
    end
  endtask : cmp_cfg

  // Pointer, then n data bytes; bytes outside the bank are dropped.
  task automatic wr_regs(input logic [7:0] ptr, input int n);
    host.start_cond();
    host.xfer({ADDR, 2'b01}, r);
    cmp_b("address ack", 8'h00, {7'h00, r[0]});
    host.xfer({ptr, 1'b1}, r);
    for (int i = 0; i < n; i++) begin
      host.xfer({wd[i], 1'b1}, r);
      if (ptr + i <= 8'h25) img[3'(ptr + i - 8'h1E)] = wd[i];
    end
    host.stop_cond();
  endtask : wr_regs

  // Pointer write, repeated start, n bytes read; the last one is not acknowledged.
  task automatic rd_regs(input logic [7:0] ptr, input int n);
    logic [7:0] p;
    host.start_cond();
    host.xfer({ADDR, 2'b01}, r);
    host.xfer({ptr, 1'b1}, r);
    host.start_cond();
    host.xfer({ADDR, 2'b11}, r);
    for (int i = 0; i < n; i++) begin
      p = ptr + 8'(i);
      host.xfer({8'hFF, i == n - 1}, r);
      if (p >= 8'h1E && p <= 8'h25) cmp_b("register read", rd_exp(3'(p - 8'h1E)), r[8:1]);
      else cmp_b("unmapped read", 8'h00, r[8:1]);
    end
    host.stop_cond();
  endtask : rd_regs

  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Main sequence: reset view, then mode sweeps mixed with random bytes.
  initial begin
    rst_b_i = 1'b0;
    seed = 16'h543C;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    img = '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h28, 8'h03, 8'h08, 8'h00};
    cmp_cfg(cfg_exp());
    repeat (4) @(negedge clk_sys_i);
    rd_regs(8'h1E, 8);
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 8; j++) begin
        seed = lfsr(seed);
        wd[j] = seed[7:0];
      end
      // The host keeps reserved bits at reset level and uses supported codes only.
      wd[0][7:6] = 2'b00;
      wd[3] = {4'h0, k[0] ? 2'b11 : 2'b00, k[1] ? 2'b11 : 2'b00};
      wd[4] = {2'b00, k[1], 1'b0, k[2] ? 4'h8 : 4'h4};
      wd[5] = {1'b0, 3'(k), 1'b0, k[0], 2'b11};
      wd[7] = {5'h00, 3'(7 - k)};
      if (k == 0) {wd[0], wd[1], wd[2], wd[6]} = 32'h3FFFFFFF;
      wr_regs(8'h1E, 8);
      cmp_cfg(cfg_exp());
      rd_regs(8'h1E, 8);
    end
    host.start_cond();
    host.xfer({ADDR ^ 7'h01, 2'b01}, r);
    cmp_b("foreign address nack", 8'h01, {7'h00, r[0]});
    host.stop_cond();
    wd[0] = 8'h5A;
    wr_regs(8'h30, 1);
    rd_regs(8'h30, 1);
    cmp_cfg(cfg_exp());
    close_out();
  end

  // Bound on the whole run, well above what the sequence needs.
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    err_count++;
    close_out();
  end
endmodule : pll_fractional_loop_config_bank_tb

bind pll_fractional_loop_config_bank loop_cfg_props props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .loop_cfg_o(loop_cfg_o));
